//--- io_cmd_regs.svh
`ifndef IO_CMD_REGS_SVH
`define IO_CMD_REGS_SVH

// ----------------------------------------
// Command item type codes
// ----------------------------------------
`define CMD_BIT_DIR_READ   8'h0c
`define CMD_BIT_DIR_WRITE  8'h0d
`define CMD_PORT_ST_READ   8'h1a
`define CMD_PORT_ST_WRITE  8'h1b
`define CMD_PORT_DIR_READ  8'h1c
`define CMD_PORT_DIR_WRITE 8'h1d
`define CMD_AOUT8_CH0      8'h22
`define CMD_AOUT8_CH1      8'h23
`define CMD_AOUT16_CH0     8'h26
`define CMD_AOUT16_CH1     8'h27

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define LINE_NUM_MSB       4
`define DIR_BIT_POS        7
`define LINE_COUNT         20
`define PORT_A_LO          0
`define PORT_B_LO          8
`define PORT_C_LO          16
`define PORT_C_WIDTH       4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DIR_RESET          20'h00000
`define LEVEL_RESET        20'h00000
`define AOUT_RESET         16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define GROUP_UPDATE_NS    1000
`define CLK_PERIOD_NS      10
`define GROUP_STEP_CYCLES  1

`endif

//--- io_cmd_pkg.sv
package io_cmd_pkg;

  // Decoder states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COLLECT,
    ST_APPLY
  } cmd_state_t;

  // Byte and line vector types
  typedef logic [7:0]  byte_t;
  typedef logic [19:0] line_vec_t;

endpackage

//--- io_direction_state_dac_commands.sv
// Notes on behaviour
// - Type 12 reports one line's direction
// - Direction report ignores analog configuration
// - Lines 0-7 A, 8-15 B, 16-19 C
// - Direction one is output, zero input
// - Type 13 sets one direction, no reply
// - Type 26 returns three bytes of levels
// - Analog-line level bits are meaningless
// - Bit n is line n, one high
// - Type 27 masked lines forced output, driven
// - Unmasked lines stay unchanged
// - Bytes ordered port A, B, C
// - Groups updated in order within 1 us
// - Type 28 returns three direction bytes
// - Type 29 sets masked directions, no reply
// - Types 34/35 load 8-bit analog value
// - Types 38/39 load 16-bit value, LSB first
`include "io_cmd_regs.svh"

module io_direction_state_dac_commands #(
  parameter int LINES = `LINE_COUNT
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Command byte stream
  input  wire logic              cmdValid,
  input  wire io_cmd_pkg::byte_t cmdByte,
  input  wire logic              cmdStart,
  // Response byte stream
  output logic                   rspValid,
  output io_cmd_pkg::byte_t      rspByte,
  output logic                   cmdDone,
  // Digital lines, pin side
  input  wire logic [19:0]       lineLevelIn,
  output logic [19:0]            lineLevelOut,
  output logic [19:0]            lineDriveOut,
  // Analog output channels
  output logic [15:0]            analogOutChannelZero,
  output logic [15:0]            analogOutChannelOne,
  output logic                   aoutEightBitMode
);
  import io_cmd_pkg::*;
  // Shared byte, line and state types

  // Elaboration check on line count
  // Port widths and group masks assume twenty lines
  // Any other count is refused at build time
  if (LINES != `LINE_COUNT) begin : g_bad_lines
    $error("line count must be twenty");
  end

  // ----------------------------------------
  // State and storage
  // ----------------------------------------
  // All state in flip-flops, cleared by reset
  // Parameter bytes indexed by arrival order
  cmd_state_t  state_r;               // Decoder state
  byte_t       cmdType_r;             // Current command type
  byte_t       param_r [6];           // Parameter bytes
  logic [2:0]  paramCnt_r;            // Parameter bytes received
  logic [2:0]  paramNeed_r;           // Parameter bytes required
  logic [1:0]  rspCnt_r;              // Response bytes left to send
  logic [1:0]  rspIdx_r;              // Response byte index
  line_vec_t   rspSnap_r;             // Snapshot for multi-byte reply
  line_vec_t   dir_r;                 // Direction, one is output
  line_vec_t   level_r;               // Output levels
  logic [2:0]  grpStep_r;             // Group update step
  logic [7:0]  grpWait_r;             // Cycles within step
  line_vec_t   pendMask_r;            // Mask being applied
  line_vec_t   pendVal_r;             // Levels being applied
  logic        rspValid_r;            // Reply byte strobe
  byte_t       rspByte_r;             // Reply byte
  logic        cmdDone_r;             // Item finished pulse
  logic [15:0] aout0_r;               // Analog channel zero code
  logic [15:0] aout1_r;               // Analog channel one code
  logic        aout8_r;               // Last load was eight bit
  logic        grpBusy_r;             // Group walk running
  logic        applied_r;             // Command action issued

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Type byte decoded straight off the stream
  // Parameter count sets how many bytes to collect
  // Unknown types never leave idle
  // Cycles per group step, nine steps fit the window
  localparam int STEP_CYC = (`GROUP_UPDATE_NS / `CLK_PERIOD_NS) / 16;
  wire [2:0]  needOfType;             // Parameter count per type
  wire        knownType;              // Type belongs to this block
  wire        byteIn   = cmdValid;
  // Line number and direction from the first parameter
  // Masks and values packed port A, B, C
  wire [4:0]  lineNum  = param_r[0][`LINE_NUM_MSB:0];
  wire        lineOk   = lineNum < 5'd20;
  wire        dirBit   = param_r[0][`DIR_BIT_POS];
  wire line_vec_t maskVec = {param_r[2][3:0], param_r[1], param_r[0]};
  wire line_vec_t valVec  = {param_r[5][3:0], param_r[4], param_r[3]};
  // Count reaches need on the final parameter
  wire        lastParam = (paramCnt_r + 3'd1 == paramNeed_r);

  // Types handled by this block
  assign knownType = (cmdByte == `CMD_BIT_DIR_READ)  || (cmdByte == `CMD_BIT_DIR_WRITE) ||
                     (cmdByte == `CMD_PORT_ST_READ)  || (cmdByte == `CMD_PORT_ST_WRITE) ||
                     (cmdByte == `CMD_PORT_DIR_READ) || (cmdByte == `CMD_PORT_DIR_WRITE) ||
                     (cmdByte == `CMD_AOUT8_CH0)     || (cmdByte == `CMD_AOUT8_CH1) ||
                     (cmdByte == `CMD_AOUT16_CH0)    || (cmdByte == `CMD_AOUT16_CH1);
  // Parameter bytes that follow each type
  assign needOfType =
      (cmdByte == `CMD_BIT_DIR_READ || cmdByte == `CMD_BIT_DIR_WRITE) ? 3'd1 :
      (cmdByte == `CMD_PORT_ST_WRITE || cmdByte == `CMD_PORT_DIR_WRITE) ? 3'd6 :
      (cmdByte == `CMD_AOUT8_CH0 || cmdByte == `CMD_AOUT8_CH1) ? 3'd1 :
      (cmdByte == `CMD_AOUT16_CH0 || cmdByte == `CMD_AOUT16_CH1) ? 3'd2 : 3'd0;

  // Group masks in update order: A4-5, A6-7, A0-3, B0-5, B6-7, C0..C3
  // Lines of one group switch together
  // Mask of zero past the last group
  function automatic line_vec_t grpMask(input logic [3:0] g);
    case (g)
      4'h0:    grpMask = 20'h00030;
      4'h1:    grpMask = 20'h000c0;
      4'h2:    grpMask = 20'h0000f;
      4'h3:    grpMask = 20'h03f00;
      4'h4:    grpMask = 20'h0c000;
      4'h5:    grpMask = 20'h10000;
      4'h6:    grpMask = 20'h20000;
      4'h7:    grpMask = 20'h40000;
      4'h8:    grpMask = 20'h80000;
      default: grpMask = 20'h00000;
    endcase
  endfunction

  // Group counter extends to nine groups
  logic       grpHi_r;                // Step above seven
  wire [3:0]  grpIdx  = {grpHi_r, grpStep_r};
  wire line_vec_t curGrp = grpMask(grpIdx) & pendMask_r;
  wire        stepEnd = (grpWait_r == 8'(STEP_CYC - 1));

  // ----------------------------------------
  // Command state machine
  // ----------------------------------------
  // Idle waits for a known type byte with start
  // Collect stores parameters in arrival order
  // Apply holds until replies and walk are over
  // Bytes arriving while busy are dropped
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // Back to idle, parameters cleared
      state_r     <= ST_IDLE;
      cmdType_r   <= 8'h00;
      paramCnt_r  <= 3'h0;
      paramNeed_r <= 3'h0;
      for (int i = 0; i < 6; i++) param_r[i] <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Type byte opens a new item
          if (byteIn && cmdStart && knownType) begin
            cmdType_r   <= cmdByte;
            paramNeed_r <= needOfType;
            paramCnt_r  <= 3'h0;
            // Types without parameters go straight to apply
            state_r     <= (needOfType == 3'd0) ? ST_APPLY : ST_COLLECT;
          end
        end
        ST_COLLECT: begin
          // Store byte, move on after the last
          if (byteIn) begin
            param_r[paramCnt_r] <= cmdByte;
            paramCnt_r          <= paramCnt_r + 3'd1;
            if (lastParam) begin
              state_r <= ST_APPLY;
            end
          end
        end
        ST_APPLY: begin
          // Leave when reply sent and group walk finished
          if (rspCnt_r == 2'd0 && grpIdx == 4'h0 && !grpBusy_r && applied_r) begin
            state_r <= ST_IDLE;
          end
        end
        // Unused encoding falls back to idle
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Execution
  // ----------------------------------------
  // High for the first apply cycle only
  wire  enterApply = (state_r == ST_APPLY) && !applied_r;

  // One cycle of action on entry to apply
  // Reads take a snapshot, replies shift out later
  // Writes land here, state writes start the group walk
  // Walk and reply counters run in later cycles
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // Lines inputs and low, analog codes zero
      dir_r      <= `DIR_RESET;
      level_r    <= `LEVEL_RESET;
      aout0_r    <= `AOUT_RESET;
      aout1_r    <= `AOUT_RESET;
      aout8_r    <= 1'b0;
      applied_r  <= 1'b0;
      grpBusy_r  <= 1'b0;
      grpStep_r  <= 3'h0;
      grpHi_r    <= 1'b0;
      grpWait_r  <= 8'h00;
      pendMask_r <= 20'h00000;
      pendVal_r  <= 20'h00000;
      rspCnt_r   <= 2'd0;
      rspIdx_r   <= 2'd0;
      rspSnap_r  <= 20'h00000;
    end else begin
      // Re-arm once the item has left apply
      if (state_r != ST_APPLY) applied_r <= 1'b0;
      if (enterApply) begin
        applied_r <= 1'b1;
        case (cmdType_r)
          // Single direction, answer in bit 0
          `CMD_BIT_DIR_READ: begin
            rspSnap_r <= {19'h0, lineOk & dir_r[lineNum]};
            rspCnt_r  <= 2'd1;
          end
          // Single direction write, out of range ignored
          `CMD_BIT_DIR_WRITE: begin
            if (lineOk) dir_r[lineNum] <= dirBit;
          end
          // Snapshot of all pin levels
          `CMD_PORT_ST_READ: begin
            rspSnap_r <= lineLevelIn;
            rspCnt_r  <= 2'd3;
          end
          // Latch mask and levels, start the walk
          `CMD_PORT_ST_WRITE: begin
            pendMask_r <= maskVec;
            pendVal_r  <= valVec;
            grpBusy_r  <= 1'b1;
            grpStep_r  <= 3'h0;
            grpHi_r    <= 1'b0;
            grpWait_r  <= 8'h00;
          end
          // Snapshot of all directions
          `CMD_PORT_DIR_READ: begin
            rspSnap_r <= dir_r;
            rspCnt_r  <= 2'd3;
          end
          // Masked direction update in one cycle
          `CMD_PORT_DIR_WRITE: begin
            dir_r <= (dir_r & ~maskVec) | (valVec & maskVec);
          end
          // Eight bit code into the upper byte
          `CMD_AOUT8_CH0: begin
            aout0_r <= {param_r[0], 8'h00};
            aout8_r <= 1'b1;
          end
          // Same for channel one
          `CMD_AOUT8_CH1: begin
            aout1_r <= {param_r[0], 8'h00};
            aout8_r <= 1'b1;
          end
          // Sixteen bit code, low byte came first
          `CMD_AOUT16_CH0: begin
            aout0_r <= {param_r[1], param_r[0]};
            aout8_r <= 1'b0;
          end
          // Same for channel one
          `CMD_AOUT16_CH1: begin
            aout1_r <= {param_r[1], param_r[0]};
            aout8_r <= 1'b0;
          end
          default: ;
        endcase
        // Reply always starts at port A
        rspIdx_r <= 2'd0;
      end else begin
        // Group walk, each group switches at once
        if (grpBusy_r) begin
          grpWait_r <= stepEnd ? 8'h00 : grpWait_r + 8'h01;
          // First cycle of each step moves the group
          if (grpWait_r == 8'h00) begin
            dir_r   <= dir_r | curGrp;
            level_r <= (level_r & ~curGrp) | (pendVal_r & curGrp);
          end
          // Advance, or stop after the last group
          if (stepEnd) begin
            if (grpIdx == 4'h8) begin
              grpBusy_r <= 1'b0;
              grpStep_r <= 3'h0;
              grpHi_r   <= 1'b0;
            end else begin
              {grpHi_r, grpStep_r} <= grpIdx + 4'h1;
            end
          end
        end
        // Response byte sequencing, port A first
        // One byte per cycle until the count runs out
        if (rspCnt_r != 2'd0) begin
          rspCnt_r <= rspCnt_r - 2'd1;
          rspIdx_r <= rspIdx_r + 2'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // Response and outputs
  // ----------------------------------------
  // Reply bytes leave one per cycle from the snapshot
  // Done pulses once everything has settled
  wire  rspFire = (state_r == ST_APPLY) && applied_r && (rspCnt_r != 2'd0);
  wire  finish  = (state_r == ST_APPLY) && applied_r && (rspCnt_r == 2'd0) && !grpBusy_r;
  wire byte_t rspSel = (rspIdx_r == 2'd0) ? rspSnap_r[7:0] :
                       (rspIdx_r == 2'd1) ? rspSnap_r[15:8] :
                                            {4'h0, rspSnap_r[19:16]};

  // Registered response and done strobes
  // Byte forced to zero when idle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // No reply, no done
      rspValid_r <= 1'b0;
      rspByte_r  <= 8'h00;
      cmdDone_r  <= 1'b0;
    end else begin
      rspValid_r <= rspFire;
      rspByte_r  <= rspFire ? rspSel : 8'h00;
      cmdDone_r  <= finish;
    end
  end

  // Ports follow their flops directly
  assign rspValid             = rspValid_r;
  assign rspByte              = rspByte_r;
  assign cmdDone              = cmdDone_r;
  assign lineLevelOut         = level_r;
  assign lineDriveOut         = dir_r;
  assign analogOutChannelZero = aout0_r;
  assign analogOutChannelOne  = aout1_r;
  assign aoutEightBitMode     = aout8_r;

endmodule // io_direction_state_dac_commands

//--- io_cmd_checker_props.sv
module io_cmd_checker #(
  parameter int LINES = 20
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset,
  // Command and response streams
  input wire logic              cmdValid,
  input wire io_cmd_pkg::byte_t cmdByte,
  input wire logic              cmdStart,
  input wire logic              rspValid,
  input wire io_cmd_pkg::byte_t rspByte,
  input wire logic              cmdDone,
  // Lines and analog outputs
  input wire logic [19:0]       lineLevelIn,
  input wire logic [19:0]       lineLevelOut,
  input wire logic [19:0]       lineDriveOut,
  input wire logic [15:0]       analogOutChannelZero,
  input wire logic [15:0]       analogOutChannelOne,
  input wire logic              aoutEightBitMode
);
  import io_cmd_pkg::*;
  // ----------------------------------------
  // Item tracking
  // ----------------------------------------
  logic  busy_r;      // Item in progress
  byte_t lastType_r;  // Type of current item
  logic [7:0] busyCnt_r;  // Cycles spent busy
  wire   taken = cmdValid && cmdStart && !busy_r;
  // Latch type, count busy cycles
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_r     <= 1'b0;
      lastType_r <= 8'h00;
      busyCnt_r  <= 8'h00;
    end else begin
      if (taken) begin
        busy_r     <= 1'b1;
        lastType_r <= cmdByte;
      end else if (cmdDone) begin
        busy_r <= 1'b0;
      end
      busyCnt_r <= busy_r ? busyCnt_r + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  rsp_idle_zero_a: assert property (!rspValid |-> rspByte == 8'h00) else $error("response byte not zero");
  done_one_cycle_a: assert property (cmdDone |=> !cmdDone) else $error("done longer than one cycle");
  no_reply_a: assert property (rspValid |-> lastType_r inside {8'h0c, 8'h1a, 8'h1c})
    else $error("response from a silent item");
  dir_bit_zero_a: assert property (rspValid && lastType_r == 8'h0c |-> rspByte[7:1] == 7'h00)
    else $error("single direction reply upper bits set");
  read_walk_a: assert property (taken && cmdByte inside {8'h1a, 8'h1c} |-> ##3 rspValid [*3] ##1 cmdDone)
    else $error("three byte read walk wrong");
  dir_bytes_a: assert property (taken && cmdByte == 8'h1c |-> ##3 rspByte == lineDriveOut[7:0]
    ##1 rspByte == lineDriveOut[15:8] ##1 rspByte == {4'h0, lineDriveOut[19:16]}) else $error("direction bytes wrong");
  state_byte_a: assert property (taken && cmdByte == 8'h1a |-> ##3 rspByte == lineLevelIn[7:0])
    else $error("state byte wrong");
  walk_time_a: assert property (busy_r && lastType_r == 8'h1b |-> busyCnt_r <= 8'd120)
    else $error("state write too slow");
  drive_cause_a: assert property ($changed(lineDriveOut) |-> busy_r && lastType_r inside {8'h0d, 8'h1b, 8'h1d})
    else $error("direction changed without cause");
  level_cause_a: assert property ($changed(lineLevelOut) |-> busy_r && lastType_r == 8'h1b)
    else $error("level changed without cause");
  aout_cause_a: assert property ($changed(analogOutChannelOne) |-> busy_r && lastType_r inside {8'h23, 8'h27})
    else $error("channel one changed without cause");
endmodule // io_cmd_checker

bind io_direction_state_dac_commands io_cmd_checker #(.LINES(LINES)) i_io_cmd_checker (
  .core_clk(core_clk), .reset(reset), .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdStart(cmdStart),
  .rspValid(rspValid), .rspByte(rspByte), .cmdDone(cmdDone), .lineLevelIn(lineLevelIn),
  .lineLevelOut(lineLevelOut), .lineDriveOut(lineDriveOut), .analogOutChannelZero(analogOutChannelZero),
  .analogOutChannelOne(analogOutChannelOne), .aoutEightBitMode(aoutEightBitMode));

//--- line_pins_model.sv
module line_pins_model (
  // Device pin side
  input  wire logic [19:0] lineLevelOut,
  input  wire logic [19:0] lineDriveOut,
  // Outside world level on undriven lines
  input  wire logic [19:0] extLevel,
  output logic [19:0]      lineLevelIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven lines read back, inputs see the outside world
  assign lineLevelIn = (lineDriveOut & lineLevelOut) | (~lineDriveOut & extLevel);
endmodule // line_pins_model

//--- io_direction_state_dac_commands_tb.sv
module io_direction_state_dac_commands_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef io_cmd_pkg::byte_t bq_t[$];
  logic core_clk, reset, cmdValid, cmdStart, rspValid, cmdDone, aoMode;
  io_cmd_pkg::byte_t cmdByte, rspByte;
  logic [19:0] lvlIn, lvlOut, drv, extLevel, dirExp;
  logic [15:0] ao0, ao1;
  int err_total, check_count, cyc, waitCyc;
  bq_t rsp;
  io_direction_state_dac_commands i_io_direction_state_dac_commands (.core_clk(core_clk), .reset(reset),
    .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdStart(cmdStart), .rspValid(rspValid), .rspByte(rspByte),
    .cmdDone(cmdDone), .lineLevelIn(lvlIn), .lineLevelOut(lvlOut), .lineDriveOut(drv),
    .analogOutChannelZero(ao0), .analogOutChannelOne(ao1), .aoutEightBitMode(aoMode));
  line_pins_model i_line_pins_model (.lineLevelOut(lvlOut), .lineDriveOut(drv), .extLevel(extLevel),
    .lineLevelIn(lvlIn));
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(string name, logic [23:0] exp, logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Send one item, gather replies until done
  task automatic item(bq_t b);
    int k;
    rsp.delete();
    @(posedge core_clk);
    foreach (b[i]) begin
      cmdValid <= 1'b1;
      cmdStart <= (i == 0);
      cmdByte  <= b[i];
      @(posedge core_clk);
    end
    cmdValid <= 1'b0;
    cmdStart <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge core_clk);
      #1;
      if (rspValid === 1'b1) rsp.push_back(rspByte);
      if (cmdDone === 1'b1) break;
    end
    waitCyc = k;
    chk("done", 24'h1, {23'h0, cmdDone});
  endtask
  task automatic t_bitdir();
    int n[6] = '{0, 7, 8, 15, 16, 19};
    foreach (n[i]) begin
      item('{8'h0d, 8'h80 | n[i][7:0]});
      dirExp[n[i]] = 1'b1;
      chk("dir", {4'h0, dirExp}, {4'h0, drv});
      chk("nrsp", 24'h0, 24'(rsp.size()));
      item('{8'h0c, n[i][7:0]});
      chk("rdbit", 24'h1, {16'h0, rsp[0]});
    end
    item('{8'h0d, 8'h08});
    dirExp[8] = 1'b0;
    item('{8'h0c, 8'h08});
    chk("rdclr", 24'h0, {16'h0, rsp[0]});
    item('{8'h0d, 8'h94});
    chk("range", {4'h0, dirExp}, {4'h0, drv});
    $display("test bitdir done");
  endtask
  task automatic t_portdir();
    item('{8'h1d, 8'hff, 8'h00, 8'h0f, 8'h07, 8'h07, 8'h01});
    dirExp = 20'h18007;
    chk("pdir", {4'h0, dirExp}, {4'h0, drv});
    item('{8'h1c});
    chk("prd", {4'h0, dirExp}, {rsp[2], rsp[1], rsp[0]});
    $display("test portdir done");
  endtask
  task automatic t_state();
    item('{8'h1b, 8'hf0, 8'h00, 8'h03, 8'hab, 8'hcd, 8'hef});
    dirExp = dirExp | 20'h300f0;
    chk("sdrv", {4'h0, dirExp}, {4'h0, drv});
    chk("slvl", 24'h300a0, {4'h0, lvlOut});
    chk("stime", 24'h1, {23'h0, waitCyc < 100});
    item('{8'h1a});
    chk("srd", {4'h0, (dirExp & 20'h300a0) | (~dirExp & extLevel)}, {rsp[2], rsp[1], rsp[0]});
    item('{8'h1b, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f});
    item('{8'h1a});
    chk("sall", 24'd1048575, {rsp[2], rsp[1], rsp[0]});
    $display("test state done");
  endtask
  task automatic t_analog();
    item('{8'h22, 8'hff});
    chk("a8z", 24'hff00, {8'h0, ao0});
    chk("m8", 24'h1, {23'h0, aoMode});
    item('{8'h23, 8'h01});
    chk("a8o", 24'h0100, {8'h0, ao1});
    chk("a8k", 24'hff00, {8'h0, ao0});
    item('{8'h26, 8'h22, 8'h11});
    chk("a16z", 24'h1122, {8'h0, ao0});
    chk("m16", 24'h0, {23'h0, aoMode});
    item('{8'h27, 8'hff, 8'hff});
    chk("a16o", 24'hffff, {8'h0, ao1});
    $display("test analog done");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    cmdValid = 1'b0;
    cmdStart = 1'b0;
    cmdByte = 8'h00;
    extLevel = 20'h5a5a5;
    dirExp = 20'h00000;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    chk("rdrv", 24'h0, {4'h0, drv | lvlOut});
    t_bitdir();
    t_portdir();
    t_state();
    t_analog();
    close_out();
  end
endmodule // io_direction_state_dac_commands_tb
